// file: rtl/bade_pkg.sv
// Constants, types and register map of the BCD adjust / decrement executor
// Functional notes
// - Compare-skip takes one, two or three cycles
// - Skipped cycles do nothing in all four phases
// - Skip next when file below working register
// - Low nibble plus six when above nine
// - High nibble adds six plus digit carry
// - Single-word operand-free decimal adjust, opcode 0007
// - Decrement file, destination bit picks target
// - Access bit picks access bank or bank
// - Extended set uses indexed offset up to 95
package bade_pkg;
   localparam int BADE_AW = 12;
   // APB register byte offsets
   localparam logic [7:0] BADE_OFF_CTRL = 8'h00;
   localparam logic [7:0] BADE_OFF_WREG = 8'h04;
   localparam logic [7:0] BADE_OFF_STAT = 8'h08;
   localparam logic [7:0] BADE_OFF_BANK = 8'h0C;
   localparam logic [7:0] BADE_OFF_IDX = 8'h10;
   localparam logic [7:0] BADE_OFF_EXEC = 8'h14;
   // Field positions
   localparam int BADE_CTRL_EXT_BIT = 0;
   localparam int BADE_STAT_C_BIT = 0;
   localparam int BADE_STAT_DCARRY_BIT = 1;
   localparam int BADE_STAT_Z_BIT = 2;
   localparam int BADE_EXEC_DISC_BIT = 0;
   localparam int BADE_EXEC_LEFT_LSB = 1;
   localparam int BADE_EXEC_CYC_LSB = 4;
   // Reset values
   localparam logic [7:0] BADE_WREG_RST = 8'h00;
   localparam logic [3:0] BADE_BANK_RST = 4'h0;
   localparam logic [BADE_AW-1:0] BADE_IDX_RST = 12'h000;
   // Opcodes
   localparam logic [6:0] BADE_OPC_CMPLT = 7'b0110_000;
   localparam logic [15:0] BADE_OPC_DEC_ADJ = 16'h0007;
   localparam logic [5:0] BADE_OPC_DEC_FILE = 6'b0000_01;
   // Arithmetic and addressing constants
   localparam logic [4:0] BADE_BCD_MAX = 5'h09;
   localparam logic [4:0] BADE_BCD_FIX = 5'h06;
   localparam logic [7:0] BADE_IDX_LIMIT = 8'h5F;
   localparam logic [3:0] BADE_ACC_HI_BANK = 4'hF;
   // Phase numbering inside one instruction cycle
   localparam logic [1:0] BADE_Q1 = 2'd0;
   localparam logic [1:0] BADE_Q2 = 2'd1;
   localparam logic [1:0] BADE_Q3 = 2'd2;
   localparam logic [1:0] BADE_Q4 = 2'd3;
   localparam int BADE_NPHASE = 4;

   typedef enum logic [1:0] {
      BADE_OP_NONE = 2'b00,
      BADE_OP_CMPLT = 2'b01,
      BADE_OP_DEC_ADJ = 2'b10,
      BADE_OP_DEC_FILE = 2'b11
   } bade_op_t;

   typedef enum logic {
      BADE_ST_RUN = 1'b0,
      BADE_ST_DISC = 1'b1
   } bade_state_t;
endpackage

// file: rtl/bade_phase.sv
// Phase sequencer: steps through the phases of one instruction cycle
`timescale 1ns/10ps
module bade_phase #(
   parameter int NPH = 4,
   parameter int PW = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic [PW-1:0] phase_r
);
   logic [PW-1:0] phase_nxt;

   always_comb begin
      if (phase_r == PW'(NPH - 1)) begin
         phase_nxt = '0;
      end else begin
         phase_nxt = phase_r + PW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= '0;
      end else begin
         phase_r <= phase_nxt;
      end
   end
endmodule // bade_phase

// file: rtl/bade_exec.sv
// Executor for compare-skip-if-less, decimal adjust and decrement file
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module bade_exec #(
   parameter int AW = bade_pkg::BADE_AW
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic next_two_word,
   output logic instr_ack,
   output logic discard_cycle,
   output logic [AW-1:0] mem_addr,
   output logic mem_re,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);
   import bade_pkg::*;

   logic [1:0] phase;
   bade_state_t state_r, state_nxt;
   bade_op_t op_r, op_nxt;
   logic [15:0] ir_r, ir_nxt;
   logic [7:0] opnd_r, opnd_nxt;
   logic [7:0] res_r, res_nxt;
   logic skip_r, skip_nxt;
   logic two_r, two_nxt;
   logic [1:0] left_r, left_nxt;
   logic [1:0] cyc_r, cyc_nxt;
   logic [1:0] last_r, last_nxt;
   logic ext_r, ext_nxt;
   logic [7:0] wreg_r, wreg_nxt;
   logic c_r, c_nxt;
   logic dcarry_r, dcarry_nxt;
   logic z_r, z_nxt;
   logic newc_r, newc_nxt;
   logic newz_r, newz_nxt;
   logic [3:0] bank_r, bank_nxt;
   logic [AW-1:0] idx_r, idx_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt;
   logic pslverr_nxt;
   logic ack_nxt;
   logic disc_nxt;
   logic [AW-1:0] addr_nxt;
   logic re_nxt;
   logic we_nxt;
   logic [7:0] wdata_nxt;
   logic apb_wr;
   logic mapped;
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic lo_carry;

   bade_phase #(
      .NPH(BADE_NPHASE),
      .PW(2)
   ) u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .phase_r(phase)
   );

   // Data memory address of the file operand
   function automatic logic [AW-1:0] file_addr(input logic [7:0] f,
         input logic a, input logic ext, input logic [3:0] bank,
         input logic [AW-1:0] idx);
      logic [AW-1:0] addr;
      addr = AW'({bank, f});
      if (a) begin
         addr = AW'({bank, f});
      end else if (ext && f <= BADE_IDX_LIMIT) begin
         addr = idx + AW'(f);
      end else if (f <= BADE_IDX_LIMIT) begin
         addr = AW'(f);
      end else begin
         addr = AW'({BADE_ACC_HI_BANK, f});
      end
      return addr;
   endfunction

   assign mapped = (paddr == BADE_OFF_CTRL) || (paddr == BADE_OFF_WREG) ||
                   (paddr == BADE_OFF_STAT) || (paddr == BADE_OFF_BANK) ||
                   (paddr == BADE_OFF_IDX) || (paddr == BADE_OFF_EXEC);
   assign apb_wr = psel && penable && pready && pwrite && mapped;

   // Decimal adjust arithmetic; the low correction carry feeds the high digit
   always_comb begin
      lo_sum = {1'b0, wreg_r[3:0]};
      if (lo_sum > BADE_BCD_MAX || dcarry_r) begin
         lo_sum = lo_sum + BADE_BCD_FIX;
      end
      lo_carry = lo_sum[4];
      hi_sum = {1'b0, wreg_r[7:4]} + {4'h0, lo_carry};
      if (hi_sum > BADE_BCD_MAX || c_r) begin
         hi_sum = hi_sum + BADE_BCD_FIX;
      end
   end

   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      ir_nxt = ir_r;
      opnd_nxt = opnd_r;
      res_nxt = res_r;
      skip_nxt = skip_r;
      two_nxt = two_r;
      left_nxt = left_r;
      cyc_nxt = cyc_r;
      last_nxt = last_r;
      ext_nxt = ext_r;
      wreg_nxt = wreg_r;
      c_nxt = c_r;
      dcarry_nxt = dcarry_r;
      z_nxt = z_r;
      newc_nxt = newc_r;
      newz_nxt = newz_r;
      bank_nxt = bank_r;
      idx_nxt = idx_r;
      ack_nxt = 1'b0;
      disc_nxt = discard_cycle;
      addr_nxt = mem_addr;
      re_nxt = 1'b0;
      we_nxt = 1'b0;
      wdata_nxt = mem_wdata;
      prdata_nxt = prdata;
      pready_nxt = psel && !penable && !pready;
      pslverr_nxt = psel && !penable && !pready && !mapped;

      // Read data is captured in the setup cycle and held for the access
      if (psel && !penable) begin
         case (paddr)
            BADE_OFF_CTRL: prdata_nxt = 32'(ext_r);
            BADE_OFF_WREG: prdata_nxt = 32'(wreg_r);
            BADE_OFF_STAT: prdata_nxt = 32'({z_r, dcarry_r, c_r});
            BADE_OFF_BANK: prdata_nxt = 32'(bank_r);
            BADE_OFF_IDX: prdata_nxt = 32'(idx_r);
            BADE_OFF_EXEC: prdata_nxt = 32'({last_r, 1'b0, left_r,
                                              state_r == BADE_ST_DISC});
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (apb_wr) begin
         case (paddr)
            BADE_OFF_CTRL: ext_nxt = pwdata[BADE_CTRL_EXT_BIT];
            BADE_OFF_WREG: wreg_nxt = pwdata[7:0];
            BADE_OFF_STAT: begin
               c_nxt = pwdata[BADE_STAT_C_BIT];
               dcarry_nxt = pwdata[BADE_STAT_DCARRY_BIT];
               z_nxt = pwdata[BADE_STAT_Z_BIT];
            end
            BADE_OFF_BANK: bank_nxt = pwdata[3:0];
            BADE_OFF_IDX: idx_nxt = pwdata[AW-1:0];
            default: ;
         endcase
      end

      // Execution overrides a same-cycle software write of W or status
      case (phase)
         BADE_Q1: begin
            op_nxt = BADE_OP_NONE;
            if (instr_valid) begin
               ack_nxt = 1'b1;
               ir_nxt = instr;
            end
            if (instr_valid && state_r == BADE_ST_RUN) begin
               cyc_nxt = 2'd1;
               if (instr[15:9] == BADE_OPC_CMPLT) begin
                  op_nxt = BADE_OP_CMPLT;
               end else if (instr == BADE_OPC_DEC_ADJ) begin
                  op_nxt = BADE_OP_DEC_ADJ;
               end else if (instr[15:10] == BADE_OPC_DEC_FILE) begin
                  op_nxt = BADE_OP_DEC_FILE;
               end
               if (instr[15:9] == BADE_OPC_CMPLT ||
                   instr[15:10] == BADE_OPC_DEC_FILE) begin
                  addr_nxt = file_addr(instr[7:0], instr[8], ext_r, bank_r,
                                       idx_r);
                  re_nxt = 1'b1;
               end
            end
         end
         BADE_Q2: begin
            if (op_r == BADE_OP_CMPLT || op_r == BADE_OP_DEC_FILE) begin
               opnd_nxt = mem_rdata;
            end else if (op_r == BADE_OP_DEC_ADJ) begin
               opnd_nxt = wreg_r;
            end
         end
         BADE_Q3: begin
            skip_nxt = 1'b0;
            two_nxt = next_two_word;
            case (op_r)
               BADE_OP_CMPLT: skip_nxt = opnd_r < wreg_r;
               BADE_OP_DEC_ADJ: begin
                  res_nxt = {hi_sum[3:0], lo_sum[3:0]};
                  newc_nxt = hi_sum[4] || c_r;
               end
               BADE_OP_DEC_FILE: begin
                  res_nxt = opnd_r - 8'h01;
                  newz_nxt = (opnd_r == 8'h01);
                  if (ir_r[9]) begin
                     we_nxt = 1'b1;
                     wdata_nxt = opnd_r - 8'h01;
                  end
               end
               default: ;
            endcase
         end
         BADE_Q4: begin
            case (op_r)
               BADE_OP_DEC_ADJ: begin
                  wreg_nxt = res_r;
                  c_nxt = newc_r;
               end
               BADE_OP_DEC_FILE: begin
                  z_nxt = newz_r;
                  if (!ir_r[9]) begin
                     wreg_nxt = res_r;
                  end
               end
               default: ;
            endcase
            if (state_r == BADE_ST_RUN) begin
               if (op_r == BADE_OP_CMPLT && skip_r) begin
                  state_nxt = BADE_ST_DISC;
                  left_nxt = two_r ? 2'd2 : 2'd1;
                  disc_nxt = 1'b1;
               end else if (op_r != BADE_OP_NONE) begin
                  last_nxt = cyc_r;
               end
            end else begin
               cyc_nxt = cyc_r + 2'd1;
               left_nxt = left_r - 2'd1;
               if (left_r == 2'd1) begin
                  state_nxt = BADE_ST_RUN;
                  disc_nxt = 1'b0;
                  last_nxt = cyc_r + 2'd1;
               end
            end
         end
         default: ;
      endcase
      // Discarded cycles never reach memory or W: all four phases idle
      if (state_r == BADE_ST_DISC) begin
         op_nxt = BADE_OP_NONE;
         re_nxt = 1'b0;
         we_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= BADE_ST_RUN;
         op_r <= BADE_OP_NONE;
         ir_r <= 16'h0000;
         opnd_r <= 8'h00;
         res_r <= 8'h00;
         skip_r <= 1'b0;
         two_r <= 1'b0;
         left_r <= 2'd0;
         cyc_r <= 2'd0;
         last_r <= 2'd0;
         ext_r <= 1'b0;
         wreg_r <= BADE_WREG_RST;
         c_r <= 1'b0;
         dcarry_r <= 1'b0;
         z_r <= 1'b0;
         newc_r <= 1'b0;
         newz_r <= 1'b0;
         bank_r <= BADE_BANK_RST;
         idx_r <= BADE_IDX_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         instr_ack <= 1'b0;
         discard_cycle <= 1'b0;
         mem_addr <= '0;
         mem_re <= 1'b0;
         mem_we <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         ir_r <= ir_nxt;
         opnd_r <= opnd_nxt;
         res_r <= res_nxt;
         skip_r <= skip_nxt;
         two_r <= two_nxt;
         left_r <= left_nxt;
         cyc_r <= cyc_nxt;
         last_r <= last_nxt;
         ext_r <= ext_nxt;
         wreg_r <= wreg_nxt;
         c_r <= c_nxt;
         dcarry_r <= dcarry_nxt;
         z_r <= z_nxt;
         newc_r <= newc_nxt;
         newz_r <= newz_nxt;
         bank_r <= bank_nxt;
         idx_r <= idx_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         instr_ack <= ack_nxt;
         discard_cycle <= disc_nxt;
         mem_addr <= addr_nxt;
         mem_re <= re_nxt;
         mem_we <= we_nxt;
         mem_wdata <= wdata_nxt;
      end
   end
endmodule // bade_exec

// file: testbench/bade_exec_properties.sv
// Port-level checks for the decimal adjust and decrement executor
`timescale 1ns/10ps
module bade_exec_properties #(
   parameter int AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instr_ack,
   input wire logic discard_cycle,
   input wire logic [AW-1:0] mem_addr,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_disc4; discard_cycle [*4] ##1 !discard_cycle; endsequence
   sequence s_disc8; discard_cycle [*8] ##1 !discard_cycle; endsequence
   property p_disc_len; $rose(discard_cycle) |-> s_disc4 or s_disc8; endproperty
   a_disc_len: assert property (p_disc_len) else $error("discard length");
   property p_disc_idle; discard_cycle |-> !mem_re && !mem_we; endproperty
   a_disc_idle: assert property (p_disc_idle) else $error("discard busy");
   property p_disc_src; $rose(discard_cycle) |-> $past(mem_re, 3); endproperty
   a_disc_src: assert property (p_disc_src) else $error("discard cause");
   property p_re_q2; mem_re |-> instr_ack; endproperty
   a_re_q2: assert property (p_re_q2) else $error("read phase");
   property p_ack_gap; instr_ack |=> !instr_ack [*3]; endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("ack spacing");
   property p_we_sched;
      mem_we |-> $past(mem_re, 2) && mem_addr == $past(mem_addr, 2);
   endproperty
   a_we_sched: assert property (p_we_sched) else $error("write slot");
   property p_we_data;
      mem_we |-> mem_wdata == 8'($past(mem_rdata, 2) - 8'h01);
   endproperty
   a_we_data: assert property (p_we_data) else $error("write value");
   property p_apb_rdy; psel && !penable |=> pready; endproperty
   a_apb_rdy: assert property (p_apb_rdy) else $error("no ready");
   property p_err_rdy; pslverr |-> pready && psel && penable; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("stray error");
endmodule // bade_exec_properties

bind bade_exec bade_exec_properties #(.AW(AW)) bade_exec_properties_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .instr_ack(instr_ack),
   .discard_cycle(discard_cycle), .mem_addr(mem_addr), .mem_re(mem_re),
   .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

// file: testbench/bade_mem_model.sv
// Combinational-read file memory standing in for the banked data space
`timescale 1ns/10ps
module bade_mem_model (
   input wire logic pclk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] last_r;
   // Released bus shows the inverse so a late sample cannot match
   assign mem_rdata = mem_re ? mem[mem_addr] : ~last_r;
   always @(posedge pclk) begin
      if (mem_re) begin
         last_r <= mem[mem_addr];
      end
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
   initial begin
      last_r = 8'h00;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 37 + 11);
      end
   end
endmodule // bade_mem_model

// file: testbench/tb_top.sv
// Self-checking bench for the decimal adjust and decrement executor
`timescale 1ns/10ps
module tb_top;
   import bade_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, mem_wdata, mem_rdata;
   logic [31:0] pwdata, prdata;
   logic instr_valid, next_two_word, instr_ack, discard_cycle;
   logic [15:0] instr;
   logic [11:0] mem_addr;
   logic mem_re, mem_we;
   int bad_count, checks, dcnt;
   logic [31:0] seed = 32'hb6f1_acfe;
   bade_exec bade_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr(instr),
      .next_two_word(next_two_word), .instr_ack(instr_ack),
      .discard_cycle(discard_cycle), .mem_addr(mem_addr), .mem_re(mem_re),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   bade_mem_model bade_mem_model_i (.pclk(pclk), .mem_addr(mem_addr),
      .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [8:0] dec_adjust(logic [7:0] w, logic dcarry,
         logic c);
      int lo, hi;
      lo = w[3:0];
      hi = w[7:4];
      if (lo > 9 || dcarry) lo += 6;
      hi += lo / 16;
      if (hi > 9 || c) hi += 6;
      return {c | (hi > 15), 4'(hi), 4'(lo)};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
         output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Word changes just after its predecessor is taken, so it is stable in Q1
   task automatic issue(logic [15:0] w);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (instr_ack !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      instr <= w;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #500_000;
      bad_count++;
      complete_run();
   end
   always @(posedge pclk) begin
      if (discard_cycle === 1'b1) dcnt++;
   end
   initial begin
      logic [31:0] rd, w, st, bk, ix, ex, v;
      logic [15:0] op;
      logic [11:0] ad;
      logic [8:0] r;
      logic [7:0] f, mv, em;
      logic er, a, d, ntw, skip;
      int nadj, ncyc;
      presetn = 1'b0;
      {psel, penable, pwrite, instr_valid, next_two_word} = 5'h00;
      {paddr, pwdata, instr} = 56'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      instr_valid <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0, rd, er);
         chk("reset read", 32'h0, rd);
         chk("slverr", {31'h0, i == 6}, {31'h0, er});
      end
      for (int i = 0; i < 45; i++) begin
         w = rnd() & 32'h0000_00ff;
         st = rnd() & 32'h0000_0007;
         bk = rnd() & 32'h0000_000f;
         ix = rnd() & 32'h0000_0fff;
         ex = rnd() & 32'h0000_0001;
         v = rnd();
         f = v[10] ? 8'h5F + 8'(v[11]) : v[7:0];
         {ntw, d, a} = v[14:12];
         apb(1'b1, BADE_OFF_WREG, w, rd, er);
         apb(1'b1, BADE_OFF_STAT, st, rd, er);
         apb(1'b1, BADE_OFF_BANK, bk, rd, er);
         apb(1'b1, BADE_OFF_IDX, ix, rd, er);
         apb(1'b1, BADE_OFF_CTRL, ex, rd, er);
         ad = a ? {bk[3:0], f} : (ex[0] && f <= 8'h5F) ? 12'(ix + f)
            : (f <= 8'h5F) ? {4'h0, f} : {4'hF, f};
         mv = bade_mem_model_i.mem[ad];
         em = mv;
         skip = 1'b0;
         nadj = 0;
         if (i % 3 == 0) begin
            op = {BADE_OPC_CMPLT, a, f};
            skip = mv < w[7:0];
            // A decimal adjust follows; a skip must leave no trace of it
            nadj = skip ? 0 : 1;
         end else if (i % 3 == 1) begin
            op = BADE_OPC_DEC_ADJ;
            nadj = 1;
         end else begin
            op = {BADE_OPC_DEC_FILE, d, a, f};
            mv = mv - 8'h01;
            st[2] = (mv == 8'h00);
            if (d) em = mv;
            else w = {24'h0, mv};
         end
         repeat (nadj) begin
            r = dec_adjust(w[7:0], st[1], st[0]);
            w = {24'h0, r[7:0]};
            st[0] = r[8];
         end
         ncyc = skip ? (ntw ? 3 : 2) : 1;
         dcnt = 0;
         issue(op);
         next_two_word <= ntw;
         issue((i % 3 == 0) ? BADE_OPC_DEC_ADJ : 16'h0000);
         repeat (3) issue(16'h0000);
         apb(1'b0, BADE_OFF_WREG, 32'h0, rd, er);
         chk("wreg", w, rd);
         apb(1'b0, BADE_OFF_STAT, 32'h0, rd, er);
         chk("status", st, rd);
         apb(1'b0, BADE_OFF_EXEC, 32'h0, rd, er);
         chk("cycles", ncyc << BADE_EXEC_CYC_LSB, rd);
         chk("file", em, bade_mem_model_i.mem[ad]);
         chk("discards", skip ? (ntw ? 8 : 4) : 0, dcnt);
      end
      complete_run();
   end
endmodule // tb_top
